// ### verilog/mrr_regs.svh
// constants for the move, rotate and return execution block
`ifndef MRR_REGS_SVH
`define MRR_REGS_SVH
// ------------------------------------------------------------------
// widths
// ------------------------------------------------------------------
`define MRR_FILE_AW 7
`define MRR_FILE_WORDS 128
`define MRR_DATA_W 8
`define MRR_PC_W 13
`define MRR_STACK_DEPTH 8
// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define MRR_BIT_LSB 0
`define MRR_BIT_MSB 7
`define MRR_DEST_W 1'b0
`define MRR_DEST_F 1'b1
// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define MRR_DATA_RST 8'h00
`define MRR_PC_RST 13'h0000
`define MRR_FLAG_RST 1'b0
`endif

// ### verilog/mrr_pkg.sv
// types shared by the move, rotate and return execution block
package mrr_pkg;
`include "mrr_regs.svh"
   // ---------------------------------------------------------------
   // operation selector
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      NOP_OP,
      FILE_MOVE_OP,
      ROTATE_LEFT_CARRY_OP,
      ROTATE_RIGHT_CARRY_OP,
      INTERRUPT_RETURN_OP,
      LITERAL_RETURN_OP
   } mrr_op_e;
   // ---------------------------------------------------------------
   // issued instruction fields
   // ---------------------------------------------------------------
   typedef struct packed {
      mrr_op_e op;
      logic [`MRR_FILE_AW-1:0] faddr;
      logic dest;
      logic [`MRR_DATA_W-1:0] lit;
   } mrr_instr_s;
   // ---------------------------------------------------------------
   // decoded controls
   // ---------------------------------------------------------------
   typedef struct packed {
      logic wr_w;
      logic wr_f;
      logic wr_c;
      logic wr_z;
      logic set_irq_en;
      logic pop;
      logic two_cyc;
   } mrr_ctl_s;
   // ---------------------------------------------------------------
   // flags seen outside
   // ---------------------------------------------------------------
   typedef struct packed {
      logic carry;
      logic zero;
      logic global_irq_enable;
   } mrr_flags_s;
endpackage

// ### verilog/mrr_exec.sv
// execution of file move, nop, rotates through carry and returns
// ------------------------------------------------------------------
// Notes on behaviour
// RQ1 - move takes 7-bit address and destination bit
// RQ2 - move: dest 0 to accumulator, 1 to file
// RQ3 - move updates zero flag from moved value
// RQ4 - interrupt return: pc from stack, enable set
// RQ5 - rotate left through carry, only carry changes
// RQ6 - rotate left result to accumulator or file
// RQ7 - rotate right through carry, only carry changes
// RQ8 - rotate right result to accumulator or file
// RQ9 - literal return loads accumulator, flags untouched
// RQ10 - literal return loads pc from stack top
// RQ11 - literal return takes two instruction cycles
// RQ12 - every return pops the return stack
// RQ13 - nop only advances pc, one cycle
// RQ14 - interrupt return also takes two cycles
// ------------------------------------------------------------------
`timescale 1ns/1ns
`include "mrr_regs.svh"
module mrr_exec
   import mrr_pkg::*;
#(
   parameter int PC_W = `MRR_PC_W,
   parameter int STACK_DEPTH = `MRR_STACK_DEPTH
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic issue_valid,
   input mrr_instr_s issue,
   input wire logic push_valid,
   input wire logic [PC_W-1:0] push_addr,
   input wire logic poke_valid,
   input wire logic [`MRR_FILE_AW-1:0] poke_addr,
   input wire logic [`MRR_DATA_W-1:0] poke_data,
   input wire logic [`MRR_FILE_AW-1:0] peek_addr,
   output logic ready_r,
   output logic done_r,
   output logic [`MRR_DATA_W-1:0] w_r,
   output mrr_flags_s flags_r,
   output logic [PC_W-1:0] pc_r,
   output logic [$clog2(STACK_DEPTH)-1:0] sp_r,
   output logic [`MRR_DATA_W-1:0] peek_data_r
);
   localparam int SP_W = $clog2(STACK_DEPTH);

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   // file registers, one byte each
   logic [`MRR_DATA_W-1:0] file_r [`MRR_FILE_WORDS];
   // return stack entries
   logic [PC_W-1:0] stack_r [STACK_DEPTH];

   // ---------------------------------------------------------------
   // combinational helpers
   // ---------------------------------------------------------------
   // instruction accepted this cycle
   logic take;
   // decoded controls of the issued op
   mrr_ctl_s ctl;
   // addressed file value
   logic [`MRR_DATA_W-1:0] fval;
   // value written to accumulator or file
   logic [`MRR_DATA_W-1:0] result;
   // carry produced by a rotate
   logic carry_nxt;
   // entry below the stack pointer
   logic [PC_W-1:0] stack_top_entry;
   // stack pointer after a pop
   logic [SP_W-1:0] sp_dec;
   // next sequential pc
   logic [PC_W-1:0] pc_inc;

   assign take = issue_valid & ready_r;
   assign fval = file_r[issue.faddr]; // RQ1
   assign sp_dec = sp_r - 1'b1;
   assign stack_top_entry = stack_r[sp_dec];
   assign pc_inc = pc_r + 1'b1;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   // controls per operation
   always_comb
   begin
      ctl = '0;
      unique case (issue.op)
         NOP_OP:
         begin
            // nothing but pc advance
            ctl = '0; // RQ13
         end
         FILE_MOVE_OP:
         begin
            ctl.wr_w = (issue.dest == `MRR_DEST_W); // RQ2
            ctl.wr_f = (issue.dest == `MRR_DEST_F); // RQ2
            ctl.wr_z = 1'b1; // RQ3
         end
         ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP:
         begin
            ctl.wr_w = (issue.dest == `MRR_DEST_W); // RQ6 RQ8
            ctl.wr_f = (issue.dest == `MRR_DEST_F); // RQ6 RQ8
            ctl.wr_c = 1'b1; // RQ5 RQ7
         end
         INTERRUPT_RETURN_OP:
         begin
            ctl.set_irq_en = 1'b1; // RQ4
            ctl.pop = 1'b1; // RQ12
            ctl.two_cyc = 1'b1; // RQ14
         end
         LITERAL_RETURN_OP:
         begin
            ctl.wr_w = 1'b1; // RQ9
            ctl.pop = 1'b1; // RQ10 RQ12
            ctl.two_cyc = 1'b1; // RQ11
         end
         default:
         begin
            // illegal codes act as nop
            ctl = '0;
         end
      endcase
   end

   // result and carry selection
   always_comb
   begin
      result = fval;
      carry_nxt = flags_r.carry;
      if (issue.op == ROTATE_LEFT_CARRY_OP)
      begin
         // old carry into bit 0, bit 7 out
         result = {fval[`MRR_BIT_MSB-1:`MRR_BIT_LSB], flags_r.carry}; // RQ5
         carry_nxt = fval[`MRR_BIT_MSB]; // RQ5
      end
      else if (issue.op == ROTATE_RIGHT_CARRY_OP)
      begin
         // old carry into bit 7, bit 0 out
         result = {flags_r.carry, fval[`MRR_BIT_MSB:`MRR_BIT_LSB+1]}; // RQ7
         carry_nxt = fval[`MRR_BIT_LSB]; // RQ7
      end
      else if (issue.op == LITERAL_RETURN_OP)
      begin
         // immediate goes to accumulator
         result = issue.lit; // RQ9
      end
   end

   // ---------------------------------------------------------------
   // sequencing
   // ---------------------------------------------------------------
   // two-cycle ops hold off issue for one flush cycle
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         ready_r <= 1'b1;
      else if (take && ctl.two_cyc)
         ready_r <= 1'b0; // RQ11 RQ14
      else
         ready_r <= 1'b1;
   end

   // retire pulse after the last cycle of an op
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         done_r <= 1'b0;
      else
         done_r <= (take && !ctl.two_cyc) || !ready_r;
   end

   // ---------------------------------------------------------------
   // accumulator and flags
   // ---------------------------------------------------------------
   // accumulator write
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         w_r <= `MRR_DATA_RST;
      else if (take && ctl.wr_w)
         w_r <= result; // RQ2 RQ6 RQ8 RQ9
   end

   // carry, zero and global interrupt enable
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         flags_r.carry <= `MRR_FLAG_RST;
         flags_r.zero <= `MRR_FLAG_RST;
         flags_r.global_irq_enable <= `MRR_FLAG_RST;
      end
      else if (take)
      begin
         if (ctl.wr_c)
            flags_r.carry <= carry_nxt; // RQ5 RQ7
         if (ctl.wr_z)
            flags_r.zero <= (fval == `MRR_DATA_RST); // RQ3
         if (ctl.set_irq_en)
            flags_r.global_irq_enable <= 1'b1; // RQ4
      end
   end

   // ---------------------------------------------------------------
   // file registers
   // ---------------------------------------------------------------
   // instruction write-back wins over a poke to the same byte
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < `MRR_FILE_WORDS; i++)
            file_r[i] <= `MRR_DATA_RST;
      end
      else
      begin
         if (poke_valid)
            file_r[poke_addr] <= poke_data;
         if (take && ctl.wr_f)
            file_r[issue.faddr] <= result; // RQ2 RQ6 RQ8
      end
   end

   // registered read port
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         peek_data_r <= `MRR_DATA_RST;
      else
         peek_data_r <= file_r[peek_addr];
   end

   // ---------------------------------------------------------------
   // program counter and return stack
   // ---------------------------------------------------------------
   // pc reload on return, else step
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         pc_r <= PC_W'(`MRR_PC_RST);
      else if (take && ctl.pop)
         pc_r <= stack_top_entry; // RQ4 RQ10
      else if (take)
         pc_r <= pc_inc; // RQ13
   end

   // stack pointer; a pop wins over a push in the same cycle
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         sp_r <= '0;
      else if (take && ctl.pop)
         sp_r <= sp_dec; // RQ12
      else if (push_valid)
         sp_r <= sp_r + 1'b1;
   end

   // stack entries, written by pushes only
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < STACK_DEPTH; i++)
            stack_r[i] <= PC_W'(`MRR_PC_RST);
      end
      else if (push_valid && !(take && ctl.pop))
         stack_r[sp_r] <= push_addr;
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_MOVE_W: assert property (@(posedge mclk) disable iff (sys_rst) // RQ2
      take && issue.op == FILE_MOVE_OP && !issue.dest
      |=> w_r == $past(fval))
      else $error("move to accumulator wrong");

   AST_MOVE_F: assert property (@(posedge mclk) disable iff (sys_rst) // RQ1
      take && issue.op == FILE_MOVE_OP && issue.dest
      |=> file_r[$past(issue.faddr)] == $past(fval) && $stable(w_r))
      else $error("move back to file wrong");

   AST_MOVE_Z: assert property (@(posedge mclk) disable iff (sys_rst) // RQ3
      take && issue.op == FILE_MOVE_OP
      |=> flags_r.zero == ($past(fval) == 8'h00)
          && $stable(flags_r.carry))
      else $error("move zero flag wrong");

   AST_RL: assert property (@(posedge mclk) disable iff (sys_rst) // RQ5
      take && issue.op == ROTATE_LEFT_CARRY_OP
      |=> flags_r.carry == $past(fval[7]) && $stable(flags_r.zero))
      else $error("rotate left carry wrong");

   AST_RL_DST: assert property (@(posedge mclk) disable iff (sys_rst) // RQ6
      take && issue.op == ROTATE_LEFT_CARRY_OP && !issue.dest
      |=> w_r == {$past(fval[6:0]), $past(flags_r.carry)})
      else $error("rotate left result wrong");

   AST_RR: assert property (@(posedge mclk) disable iff (sys_rst) // RQ7
      take && issue.op == ROTATE_RIGHT_CARRY_OP
      |=> flags_r.carry == $past(fval[0]) && $stable(flags_r.zero))
      else $error("rotate right carry wrong");

   AST_RR_DST: assert property (@(posedge mclk) disable iff (sys_rst) // RQ8
      take && issue.op == ROTATE_RIGHT_CARRY_OP && issue.dest
      |=> file_r[$past(issue.faddr)]
          == {$past(flags_r.carry), $past(fval[7:1])})
      else $error("rotate right result wrong");

   AST_IRET: assert property (@(posedge mclk) disable iff (sys_rst) // RQ4
      take && issue.op == INTERRUPT_RETURN_OP
      |=> pc_r == $past(stack_top_entry) && flags_r.global_irq_enable
          && $stable(flags_r.carry) && $stable(flags_r.zero))
      else $error("interrupt return wrong");

   AST_LRET: assert property (@(posedge mclk) disable iff (sys_rst) // RQ9
      take && issue.op == LITERAL_RETURN_OP
      |=> w_r == $past(issue.lit) && pc_r == $past(stack_top_entry)
          && $stable(flags_r))
      else $error("literal return wrong");

   AST_TWO_CYC: assert property (@(posedge mclk) disable iff (sys_rst) // RQ11
      take && ctl.two_cyc |=> !ready_r && !done_r ##1 ready_r && done_r)
      else $error("return not two cycles");

   AST_POP: assert property (@(posedge mclk) disable iff (sys_rst) // RQ12
      take && ctl.pop |=> sp_r == $past(sp_dec))
      else $error("return did not pop");

   AST_NOP: assert property (@(posedge mclk) disable iff (sys_rst) // RQ13
      take && issue.op == NOP_OP
      |=> pc_r == $past(pc_inc) && $stable(w_r) && $stable(flags_r)
          && done_r && ready_r)
      else $error("nop changed state");
endmodule

// ### verification/test_move_rotate_return_exec.sv
// self-checking bench for the move, rotate and return execution block
`timescale 1ns/1ns
module test_move_rotate_return_exec
   import mrr_pkg::*;
;
   // ---------------------------------------------------------------
   // stimulus, outputs and reference model
   // ---------------------------------------------------------------
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic issue_valid = 1'b0;
   mrr_instr_s issue = '0;
   logic push_valid = 1'b0;
   logic [12:0] push_addr = 13'h0000;
   logic poke_valid = 1'b0;
   logic [6:0] poke_addr = 7'h00;
   logic [7:0] poke_data = 8'h00;
   logic [6:0] peek_addr = 7'h00;
   logic ready_r;
   logic done_r;
   logic [7:0] w_r;
   mrr_flags_s flags_r;
   logic [12:0] pc_r;
   logic [2:0] sp_r;
   logic [7:0] peek_data_r;
   // model state, updated when an op is offered
   logic [7:0] m_file [128];
   logic [12:0] m_stack [8];
   logic [7:0] m_w = 8'h00;
   mrr_flags_s m_flags = '0;
   logic [12:0] m_pc = 13'h0000;
   logic [2:0] m_sp = 3'h0;
   // one note per offered op: state expected when done shows
   typedef struct packed {
      logic [7:0] w;
      mrr_flags_s fl;
      logic [12:0] pc;
      logic [2:0] sp;
      logic [31:0] cyc;
   } mrr_note_s;
   mrr_note_s notes[$];
   mrr_note_s got_n;
   int errors = 0;
   int check_count = 0;
   int seed = 32'h8d40;
   int cyc = 0;
   logic [31:0] r;
`define CHK(what, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
      end \
   end
   // ---------------------------------------------------------------
   // clock, cycle count and design
   // ---------------------------------------------------------------
   always #5 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   mrr_exec i_dut (.mclk(mclk), .sys_rst(sys_rst), .issue_valid(issue_valid),
      .issue(issue), .push_valid(push_valid), .push_addr(push_addr),
      .poke_valid(poke_valid), .poke_addr(poke_addr), .poke_data(poke_data),
      .peek_addr(peek_addr), .ready_r(ready_r), .done_r(done_r), .w_r(w_r),
      .flags_r(flags_r), .pc_r(pc_r), .sp_r(sp_r), .peek_data_r(peek_data_r));
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   // offer one op at a falling edge, note what it must leave behind
   task automatic run_op(input mrr_op_e op, input logic [6:0] a,
      input logic d, input logic [7:0] k);
      logic [7:0] v;
      logic [7:0] res;
      logic ret;
      v = m_file[a];
      res = v;
      case (op)
         FILE_MOVE_OP: m_flags.zero = (v == 8'h00);
         ROTATE_LEFT_CARRY_OP:
         begin
            res = {v[6:0], m_flags.carry};
            m_flags.carry = v[7];
         end
         ROTATE_RIGHT_CARRY_OP:
         begin
            res = {m_flags.carry, v[7:1]};
            m_flags.carry = v[0];
         end
         INTERRUPT_RETURN_OP: m_flags.global_irq_enable = 1'b1;
         LITERAL_RETURN_OP: m_w = k;
         default: ;
      endcase
      if (op inside {FILE_MOVE_OP, ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP})
      begin
         if (d)
            m_file[a] = res;
         else
            m_w = res;
      end
      ret = (op == INTERRUPT_RETURN_OP) || (op == LITERAL_RETURN_OP);
      if (ret)
      begin
         m_sp = m_sp - 3'h1;
         m_pc = m_stack[m_sp];
      end
      else
         m_pc = m_pc + 13'h0001;
      notes.push_back('{m_w, m_flags, m_pc, m_sp, cyc + (ret ? 2 : 1)});
      issue_valid = 1'b1;
      issue = '{op, a, d, k};
      @(negedge mclk);
      if (ret)
      begin
         // flush cycle: an op offered now must be ignored
         `CHK("ready in flush", 1'b0, ready_r)
         issue = '{ROTATE_LEFT_CARRY_OP, a ^ 7'h01, 1'b0, ~k};
         @(negedge mclk);
      end
   endtask
   // push one return address, stack kept circular like the design
   task automatic push_ret(input logic [12:0] addr);
      push_valid = 1'b1;
      push_addr = addr;
      m_stack[m_sp] = addr;
      m_sp = m_sp + 3'h1;
      @(negedge mclk);
   endtask
   // release strobes and let every offered op retire
   task automatic settle();
      int guard;
      issue_valid = 1'b0;
      push_valid = 1'b0;
      guard = 0;
      @(negedge mclk);
      while (notes.size() != 0 && guard < 8)
      begin
         @(negedge mclk);
         guard++;
      end
   endtask
   // one summary line, then the verdict
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // monitor: each done pulse retires the oldest note
   // ---------------------------------------------------------------
   always @(negedge mclk)
   begin
      if (!sys_rst && done_r === 1'b1)
      begin
         if (notes.size() == 0)
            `CHK("done without op", 1'b0, done_r)
         else
         begin
            got_n = notes.pop_front();
            `CHK("accumulator", got_n.w, w_r)
            `CHK("flags", got_n.fl, flags_r)
            `CHK("program counter", got_n.pc, pc_r)
            `CHK("stack pointer", got_n.sp, sp_r)
            `CHK("done cycle", got_n.cyc, 32'(cyc))
         end
      end
   end
   // ---------------------------------------------------------------
   // watchdog, well beyond the roughly nine hundred cycles the run needs
   // ---------------------------------------------------------------
   initial
   begin
      #200000;
      errors++;
      $display("unexpected run length: expected end seen hang");
      report_and_stop();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      for (int i = 0; i < 8; i++)
         m_stack[i] = 13'h0000;
      repeat (16) @(negedge mclk);
      `CHK("ready in reset", 1'b1, ready_r)
      `CHK("pc in reset", 13'h0000, pc_r)
      `CHK("flags in reset", 3'h0, flags_r)
      sys_rst = 1'b0;
      // load every file byte, a zero at 5 and a set msb at 127
      for (int i = 0; i < 128; i++)
      begin
         poke_valid = 1'b1;
         poke_addr = i[6:0];
         poke_data = (i == 5) ? 8'h00 : (i == 127) ? 8'h80 : 8'($random(seed));
         m_file[i] = poke_data;
         @(negedge mclk);
      end
      poke_valid = 1'b0;
      push_ret(13'h1abc);
      push_ret(13'h0123);
      push_ret(13'h1fff);
      settle();
      // boundary cases back to back, each named op code at least once, then illegal code 7
      run_op(FILE_MOVE_OP, 7'h05, 1'b1, 8'h00);
      run_op(FILE_MOVE_OP, 7'h7f, 1'b0, 8'h00);
      run_op(ROTATE_LEFT_CARRY_OP, 7'h7f, 1'b1, 8'h00);
      run_op(ROTATE_RIGHT_CARRY_OP, 7'h7f, 1'b0, 8'h00);
      run_op(NOP_OP, 7'h00, 1'b1, 8'h00);
      run_op(LITERAL_RETURN_OP, 7'h00, 1'b0, 8'hff);
      run_op(INTERRUPT_RETURN_OP, 7'h00, 1'b0, 8'h00);
      run_op(LITERAL_RETURN_OP, 7'h00, 1'b0, 8'h00);
      run_op(mrr_op_e'(3'h7), 7'h10, 1'b1, 8'h00);
      settle();
      // random stream with pushes between bursts
      for (int n = 0; n < 400; n++)
      begin
         r = $random(seed);
         if (r[3:0] == 4'h0)
         begin
            settle();
            push_ret(r[28:16]);
            settle();
         end
         else
            run_op(mrr_op_e'(r[6:4]), r[13:7], r[14], r[31:24]);
      end
      settle();
      // read back every file byte
      for (int i = 0; i < 129; i++)
      begin
         if (i > 0)
            `CHK("file byte", m_file[i-1], peek_data_r)
         peek_addr = i[6:0];
         @(negedge mclk);
      end
      // reset in mid-run: every output back to its reset value
      sys_rst = 1'b1;
      @(negedge mclk);
      `CHK("w in mid reset", 8'h00, w_r)
      `CHK("flags in mid reset", 3'h0, flags_r)
      `CHK("pc in mid reset", 13'h0000, pc_r)
      `CHK("sp in mid reset", 3'h0, sp_r)
      `CHK("ready in mid reset", 1'b1, ready_r)
      `CHK("done in mid reset", 1'b0, done_r)
      `CHK("peek in mid reset", 8'h00, peek_data_r)
      // model cleared like the design, first op right after release
      sys_rst = 1'b0;
      m_w = 8'h00;
      m_flags = '0;
      m_pc = 13'h0000;
      m_sp = 3'h0;
      for (int i = 0; i < 128; i++)
         m_file[i] = 8'h00;
      for (int i = 0; i < 8; i++)
         m_stack[i] = 13'h0000;
      run_op(FILE_MOVE_OP, 7'h7f, 1'b0, 8'h00);
      run_op(LITERAL_RETURN_OP, 7'h00, 1'b0, 8'h5a);
      settle();
      `CHK("pending ops", 0, notes.size())
      report_and_stop();
   end
endmodule
